// ==== src/sslsr_pkg.sv ====
// constants shared by the system status, lock and soft reset block
package sslsr_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [15:0] ADDR_STATUS     = 16'h2000;
	localparam logic [15:0] ADDR_SRST_CTL   = 16'h2004;
	localparam logic [15:0] ADDR_SYS_CFG2   = 16'h2005;

	// ****************************************
	// lock region address ranges and the unlocked gateway6 range
	// ****************************************
	localparam logic [15:0] MAC_FIRST       = 16'h4100;
	localparam logic [15:0] MAC_LAST        = 16'h4105;
	localparam logic [15:0] GW4_FIRST       = 16'h4106;
	localparam logic [15:0] GW4_LAST        = 16'h4109;
	localparam logic [15:0] MASK4_FIRST     = 16'h410A;
	localparam logic [15:0] MASK4_LAST      = 16'h410D;
	localparam logic [15:0] SRC4_FIRST      = 16'h410E;
	localparam logic [15:0] SRC4_LAST       = 16'h4111;
	localparam logic [15:0] LLA_FIRST       = 16'h4140;
	localparam logic [15:0] LLA_LAST        = 16'h414F;
	localparam logic [15:0] GUA_FIRST       = 16'h4150;
	localparam logic [15:0] GUA_LAST        = 16'h415F;
	localparam logic [15:0] SUB6_FIRST      = 16'h4160;
	localparam logic [15:0] SUB6_LAST       = 16'h416F;
	localparam logic [15:0] GW6_FIRST       = 16'h4170;
	localparam logic [15:0] GW6_LAST        = 16'h417F;
	localparam logic [15:0] PHY_CTL1_ADDR   = 16'h3000;
	localparam logic [15:0] PHY_CTL2_ADDR   = 16'h3001;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int          BIT_CHIP_LOCK   = 7;
	localparam int          BIT_NET_LOCK    = 6;
	localparam int          BIT_PHY_LOCK    = 5;
	localparam int          BIT_PAR_MODE    = 1;
	localparam int          BIT_SPI_MODE    = 0;
	localparam int          BIT_SRST_RUN    = 7;
	localparam logic [7:0]  SRST_CTL_RESET  = 8'h80;
	localparam logic [3:1]  STRAP_PAR       = 3'h2;
	localparam logic [3:1]  STRAP_SPI       = 3'h0;

	// ****************************************
	// soft reset timing
	// ****************************************
	localparam int          SRST_TIME_NS    = 32;
	localparam int          CLK_PERIOD_NS   = 8;
	localparam int          SRST_CYCLES     =
		(SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  SRST_CNT_LOAD   = 4'(SRST_CYCLES);

	typedef enum logic [0:0] {SSLSR_RUN, SSLSR_SRST} sslsr_state_t;

endpackage : sslsr_pkg

// ==== src/sslsr_strap.sv ====
// host mode strap capture and decode
`timescale 1ns/1ps
module sslsr_strap (
	input  wire logic       clk,
	input  wire logic       capture,
	input  wire logic [3:0] strap,
	output logic            par_mode_q,
	output logic            spi_mode_q
);

	// ****************************************
	// decode
	// ****************************************
	function automatic logic strap_is(input logic [3:0] s,
		input logic [3:1] pat);
		strap_is = (s[3:1] == pat);
	endfunction : strap_is

	logic par_mode_d;
	logic spi_mode_d;

	// straps are only looked at while reset holds, pins may be reused later
	always_comb begin
		par_mode_d = par_mode_q;
		spi_mode_d = spi_mode_q;
		if (capture) begin
			par_mode_d = strap_is(strap, sslsr_pkg::STRAP_PAR);
			spi_mode_d = strap_is(strap, sslsr_pkg::STRAP_SPI);
		end
	end

	always_ff @(posedge clk) begin
		par_mode_q <= par_mode_d;
		spi_mode_q <= spi_mode_d;
	end

	a_par_decode: assert property (@(posedge clk) capture |=>
		par_mode_q == ($past(strap[3:1]) == sslsr_pkg::STRAP_PAR))
		else $error("parallel mode flag wrong after capture");

	a_spi_decode: assert property (@(posedge clk) capture |=>
		spi_mode_q == ($past(strap[3:1]) == sslsr_pkg::STRAP_SPI))
		else $error("serial mode flag wrong after capture");

endmodule : sslsr_strap

// ==== src/sslsr_top.sv ====
// system status, configuration lock gating and software reset
// ****************************************
// ****************************************
`timescale 1ns/1ps
module sslsr_top (
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	input  wire logic        CHIP_LOCK,
	input  wire logic        NET_LOCK,
	input  wire logic        PHY_LOCK,
	input  wire logic [3:0]  MODE_STRAP,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	output logic             FWD_WR,
	output logic      [15:0] FWD_ADDR,
	output logic      [7:0]  FWD_WDATA,
	output logic             SOFT_RESET
);

	// ****************************************
	// address classes
	// ****************************************
	function automatic logic in_rng(input logic [15:0] a,
		input logic [15:0] lo, input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction : in_rng

	function automatic logic is_net_cfg(input logic [15:0] a);
		is_net_cfg =
			in_rng(a, sslsr_pkg::MAC_FIRST, sslsr_pkg::MAC_LAST) ||
			in_rng(a, sslsr_pkg::GW4_FIRST, sslsr_pkg::GW4_LAST) ||
			in_rng(a, sslsr_pkg::MASK4_FIRST, sslsr_pkg::MASK4_LAST) ||
			in_rng(a, sslsr_pkg::SRC4_FIRST, sslsr_pkg::SRC4_LAST) ||
			in_rng(a, sslsr_pkg::LLA_FIRST, sslsr_pkg::LLA_LAST) ||
			in_rng(a, sslsr_pkg::GUA_FIRST, sslsr_pkg::GUA_LAST) ||
			in_rng(a, sslsr_pkg::SUB6_FIRST, sslsr_pkg::SUB6_LAST);
	endfunction : is_net_cfg

	function automatic logic is_phy_cfg(input logic [15:0] a);
		is_phy_cfg = (a == sslsr_pkg::PHY_CTL1_ADDR) ||
			(a == sslsr_pkg::PHY_CTL2_ADDR);
	endfunction : is_phy_cfg

	function automatic logic is_sys_cfg(input logic [15:0] a);
		is_sys_cfg = (a == sslsr_pkg::ADDR_SRST_CTL) ||
			(a == sslsr_pkg::ADDR_SYS_CFG2);
	endfunction : is_sys_cfg

	// ****************************************
	// state
	// ****************************************
	sslsr_pkg::sslsr_state_t state_q, state_d;
	logic [3:0]  srst_cnt_q, srst_cnt_d;
	logic [7:0]  srst_ctl_q, srst_ctl_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        fwd_wr_q, fwd_wr_d;
	logic [15:0] fwd_addr_q, fwd_addr_d;
	logic [7:0]  fwd_data_q, fwd_data_d;
	logic        srst_out_q, srst_out_d;
	logic        par_mode;
	logic        spi_mode;
	logic        in_srst;
	logic        blocked;
	logic [7:0]  status_v;

	assign in_srst = (state_q == sslsr_pkg::SSLSR_SRST);

	// straps caught again on every reset, soft or hard
	sslsr_strap u_strap (
		.clk        (SYS_CLK),
		.capture    (RESET || in_srst),
		.strap      (MODE_STRAP),
		.par_mode_q (par_mode),
		.spi_mode_q (spi_mode)
	);

	always_comb begin
		status_v = 8'h00;
		status_v[sslsr_pkg::BIT_CHIP_LOCK] = CHIP_LOCK;
		status_v[sslsr_pkg::BIT_NET_LOCK]  = NET_LOCK;
		status_v[sslsr_pkg::BIT_PHY_LOCK]  = PHY_LOCK;
		status_v[sslsr_pkg::BIT_PAR_MODE]  = par_mode;
		status_v[sslsr_pkg::BIT_SPI_MODE]  = spi_mode;
	end

	// ****************************************
	// write gating, read path, soft reset
	// ****************************************
	always_comb begin
		state_d    = state_q;
		srst_cnt_d = srst_cnt_q;
		srst_ctl_d = srst_ctl_q;
		rdata_d    = 8'h00;
		fwd_wr_d   = 1'b0;
		fwd_addr_d = fwd_addr_q;
		fwd_data_d = fwd_data_q;
		// chip, network and phy locks; gateway6 outside the network range
		blocked = (CHIP_LOCK && is_sys_cfg(REG_ADDR)) ||
			(NET_LOCK && is_net_cfg(REG_ADDR)) ||
			(PHY_LOCK && is_phy_cfg(REG_ADDR));
		case (state_q)
			sslsr_pkg::SSLSR_RUN: begin
				if (REG_RD && REG_ADDR == sslsr_pkg::ADDR_STATUS) begin
					rdata_d = status_v;
				end
				if (REG_WR && !blocked) begin
					if (REG_ADDR == sslsr_pkg::ADDR_SRST_CTL) begin
						srst_ctl_d = REG_WDATA;
						if (!REG_WDATA[sslsr_pkg::BIT_SRST_RUN]) begin
							state_d    = sslsr_pkg::SSLSR_SRST;
							srst_cnt_d = sslsr_pkg::SRST_CNT_LOAD;
						end
					end else begin
						fwd_wr_d   = 1'b1;
						fwd_addr_d = REG_ADDR;
						fwd_data_d = REG_WDATA;
					end
				end
			end
			sslsr_pkg::SSLSR_SRST: begin
				// hold reset, soft reset control and forwarding address and data back to defaults
				srst_ctl_d = sslsr_pkg::SRST_CTL_RESET;
				fwd_addr_d = 16'h0000;
				fwd_data_d = 8'h00;
				srst_cnt_d = srst_cnt_q - 4'h1;
				if (srst_cnt_q == 4'h1) begin
					state_d = sslsr_pkg::SSLSR_RUN;
				end
			end
			default: begin
				state_d = sslsr_pkg::SSLSR_RUN;
			end
		endcase
		// registered copy, so the pin comes straight from a flop
		srst_out_d = (state_d == sslsr_pkg::SSLSR_SRST);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			state_q    <= sslsr_pkg::SSLSR_RUN;
			srst_cnt_q <= 4'h0;
			srst_ctl_q <= sslsr_pkg::SRST_CTL_RESET;
			rdata_q    <= 8'h00;
			fwd_wr_q   <= 1'b0;
			fwd_addr_q <= 16'h0000;
			fwd_data_q <= 8'h00;
			srst_out_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			srst_cnt_q <= srst_cnt_d;
			srst_ctl_q <= srst_ctl_d;
			rdata_q    <= rdata_d;
			fwd_wr_q   <= fwd_wr_d;
			fwd_addr_q <= fwd_addr_d;
			fwd_data_q <= fwd_data_d;
			srst_out_q <= srst_out_d;
		end
	end

	assign REG_RDATA  = rdata_q;
	assign FWD_WR     = fwd_wr_q;
	assign FWD_ADDR   = fwd_addr_q;
	assign FWD_WDATA  = fwd_data_q;
	assign SOFT_RESET = srst_out_q;

	// ****************************************
	// checks
	// ****************************************
	// chip lock read and cfg2 block
	a_chip_lock_read: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_RD && !in_srst && REG_ADDR == sslsr_pkg::ADDR_STATUS
		|=> REG_RDATA[sslsr_pkg::BIT_CHIP_LOCK] == $past(CHIP_LOCK))
		else $error("chip lock status bit wrong");
	a_cfg2_locked: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_WR && CHIP_LOCK && REG_ADDR == sslsr_pkg::ADDR_SYS_CFG2
		|=> !FWD_WR)
		else $error("system config write passed while chip locked");
	a_net_lock_read: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_RD && !in_srst && REG_ADDR == sslsr_pkg::ADDR_STATUS
		|=> REG_RDATA[sslsr_pkg::BIT_NET_LOCK] == $past(NET_LOCK) &&
		REG_RDATA[sslsr_pkg::BIT_PHY_LOCK] == $past(PHY_LOCK))
		else $error("network or phy lock status bit wrong");
	a_net_blocked: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_WR && NET_LOCK && is_net_cfg(REG_ADDR) |=> !FWD_WR)
		else $error("network config write passed while locked");
	a_gw6_open: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_WR && !in_srst &&
		in_rng(REG_ADDR, sslsr_pkg::GW6_FIRST, sslsr_pkg::GW6_LAST)
		|=> FWD_WR && FWD_ADDR == $past(REG_ADDR))
		else $error("ipv6 gateway write was not forwarded");
	a_phy_blocked: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_WR && is_phy_cfg(REG_ADDR)
		|=> FWD_WR == (!$past(PHY_LOCK) && !$past(in_srst)))
		else $error("phy control gating wrong");
	a_reserved_zero: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		$past(REG_RD) |-> REG_RDATA[4:2] == 3'h0)
		else $error("reserved status bits not zero");
	a_srst_locked: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_WR && CHIP_LOCK && !in_srst &&
		REG_ADDR == sslsr_pkg::ADDR_SRST_CTL |=> !SOFT_RESET)
		else $error("soft reset taken while chip locked");
	a_srst_pulse: assert property (
		@(posedge SYS_CLK) disable iff (RESET)
		REG_WR && !CHIP_LOCK && !in_srst &&
		!REG_WDATA[sslsr_pkg::BIT_SRST_RUN] &&
		REG_ADDR == sslsr_pkg::ADDR_SRST_CTL
		|=> SOFT_RESET [*4] ##1
		!SOFT_RESET && srst_ctl_q == sslsr_pkg::SRST_CTL_RESET)
		else $error("soft reset sequence wrong");

endmodule : sslsr_top

// ==== verif/sslsr_tb_top.sv ====
// self-checking bench for the status, lock and soft reset block
`timescale 1ns/1ps
module sslsr_tb_top;
	logic        sys_clk;
	logic        reset;
	logic        chip_lock;
	logic        net_lock;
	logic        phy_lock;
	logic [3:0]  mode_strap;
	logic [15:0] reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        fwd_wr;
	logic [15:0] fwd_addr;
	logic [7:0]  fwd_wdata;
	logic        soft_reset;
	int          miscompares;
	int          num_checks;

	sslsr_top dut_u (
		.SYS_CLK    (sys_clk),
		.RESET      (reset),
		.CHIP_LOCK  (chip_lock),
		.NET_LOCK   (net_lock),
		.PHY_LOCK   (phy_lock),
		.MODE_STRAP (mode_strap),
		.REG_ADDR   (reg_addr),
		.REG_WR     (reg_wr),
		.REG_RD     (reg_rd),
		.REG_WDATA  (reg_wdata),
		.REG_RDATA  (reg_rdata),
		.FWD_WR     (fwd_wr),
		.FWD_ADDR   (fwd_addr),
		.FWD_WDATA  (fwd_wdata),
		.SOFT_RESET (soft_reset)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic do_reset(input logic [3:0] strap);
		mode_strap = strap;
		reset = 1'b1;
		// count rising edges: the clock's first event is x to 0
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		@(negedge sys_clk);
	endtask : do_reset

	// leading idle edge keeps a strobe from being set twice in one step
	task automatic access(input logic wr, input logic [15:0] addr,
		input logic [7:0] data);
		@(negedge sys_clk);
		reg_wr = wr;
		reg_rd = ~wr;
		reg_addr = addr;
		reg_wdata = data;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask : access

	// ****************************************
	// scenarios
	// ****************************************
	task automatic status_scn;
		logic [3:0] straps [8] = '{4'h0, 4'h1, 4'h4, 4'h5,
			4'h2, 4'h8, 4'hC, 4'hF};
		logic [7:0] exp;
		for (int s = 0; s < 8; s++) begin
			do_reset(straps[s]);
			for (int l = 0; l < 8; l++) begin
				{chip_lock, net_lock, phy_lock} = 3'(l);
				exp = {3'(l), 3'h0, straps[s][3:1] == 3'h2,
					straps[s][3:1] == 3'h0};
				access(1'b0, 16'h2000, 8'h00);
				chk(reg_rdata, exp);
			end
		end
		access(1'b0, 16'h2004, 8'h00);
		chk(reg_rdata, 16'h0000);
		{chip_lock, net_lock, phy_lock} = 3'h0;
	endtask : status_scn

	task automatic lock_scn;
		logic [15:0] addrs [17] = '{16'h2005, 16'h4100, 16'h4105,
			16'h4109, 16'h410A, 16'h4111, 16'h4140, 16'h415F,
			16'h4160, 16'h416F, 16'h3000, 16'h3001, 16'h4170, 16'h417F,
			16'h4106, 16'h410E, 16'h4150};
		int sel [17] = '{0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 2, 2, 3, 3,
			1, 1, 1};
		for (int i = 0; i < 17; i++) begin
			for (int lk = 0; lk < 2; lk++) begin
				chip_lock = lk == 1 && sel[i] == 0;
				net_lock = lk == 1 && (sel[i] == 1 || sel[i] == 3);
				phy_lock = lk == 1 && sel[i] == 2;
				access(1'b1, addrs[i], 8'(i * 2 + lk));
				chk(fwd_wr, 16'(lk == 0 || sel[i] == 3));
				if (fwd_wr === 1'b1) begin
					chk(fwd_addr, addrs[i]);
					chk(fwd_wdata, 16'(i * 2 + lk));
				end
			end
		end
		{chip_lock, net_lock, phy_lock} = 3'h0;
	endtask : lock_scn

	task automatic srst_scn;
		int n;
		chip_lock = 1'b1;
		access(1'b1, 16'h2004, 8'h00);
		chk(soft_reset, 16'h0000);
		chk(fwd_wr, 16'h0000);
		chip_lock = 1'b0;
		access(1'b1, 16'h2004, 8'h80);
		chk(soft_reset, 16'h0000);
		chk(fwd_wr, 16'h0000);
		access(1'b1, 16'h4100, 8'h5A);
		chk(fwd_wr, 16'h0001);
		chk(fwd_addr, 16'h4100);
		@(negedge sys_clk);
		chk(fwd_wr, 16'h0000);
		// new strap must be picked up by the software reset
		mode_strap = 4'h5;
		access(1'b1, 16'h2004, 8'h00);
		n = 0;
		while (soft_reset === 1'b1 && n < 20) begin
			n++;
			if (n == 2) begin
				reg_wr = 1'b1;
				reg_addr = 16'h4170;
			end
			if (n == 3) begin
				reg_wr = 1'b0;
				chk(fwd_wr, 16'h0000);
			end
			@(negedge sys_clk);
		end
		// a stuck reset counts once here and fails the length check too
		if (n == 20) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, n,
				sslsr_pkg::SRST_CYCLES);
		end
		chk(16'(n), 16'(sslsr_pkg::SRST_CYCLES));
		chk(fwd_addr, 16'h0000);
		chk(fwd_wdata, 16'h0000);
		access(1'b0, 16'h2000, 8'h00);
		chk(reg_rdata, 16'h0002);
	endtask : srst_scn

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		miscompares = 0;
		num_checks = 0;
		{chip_lock, net_lock, phy_lock} = 3'h0;
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		do_reset(4'h4);
		chk(reg_rdata, 16'h0000);
		chk(fwd_wr, 16'h0000);
		chk(fwd_addr, 16'h0000);
		chk(fwd_wdata, 16'h0000);
		chk(soft_reset, 16'h0000);
		status_scn();
		lock_scn();
		srst_scn();
		print_verdict();
	end
endmodule : sslsr_tb_top
